// >>> logic/comb_cfg_pkg.sv
package comb_cfg_pkg;

  // Register indices; the bus byte address is the index times four
  localparam logic [11:0] IDX_SRC_RATIO_LOW  = 12'h478;
  localparam logic [11:0] IDX_SRC_RATIO_HIGH = 12'h479;
  localparam logic [11:0] IDX_COMB_BW        = 12'h47a;
  localparam logic [11:0] IDX_COMB_EN        = 12'h47b;
  localparam logic [11:0] IDX_STEP_LOW       = 12'h47c;
  localparam logic [11:0] IDX_STEP_MID       = 12'h47d;
  localparam logic [11:0] IDX_STEP_HIGH      = 12'h47e;
  localparam int          ADDR_SHIFT         = 2;
  localparam int          ADDR_W             = 14;

  // Reset values and the blend slope limit
  localparam logic [7:0] RST_SRC_RATIO_LOW  = 8'h1f;
  localparam logic [1:0] RST_SRC_RATIO_HIGH = 2'h2;
  localparam logic       RST_REDUCE_EN      = 1'h1;
  localparam logic [1:0] RST_LPF_SEL        = 2'h1;
  localparam logic [3:0] RST_BLEND_SLOPE    = 4'h8;
  localparam logic [3:0] MAX_BLEND_SLOPE    = 4'h8;
  localparam logic       RST_COMB_EN_BIT    = 1'h1;
  localparam logic [7:0] RST_STEP_LOW       = 8'h1f;
  localparam logic [7:0] RST_STEP_MID       = 8'h7c;
  localparam logic [3:0] RST_STEP_HIGH      = 4'h8;

  // Field positions
  localparam int POS_REDUCE_EN = 7;
  localparam int POS_LUMA_LPF  = 6;
  localparam int POS_CHROMA_LPF = 4;
  localparam int POS_CHECK     = 7;
  localparam int POS_C3        = 6;
  localparam int POS_C2        = 5;
  localparam int POS_RSV_RW4   = 4;
  localparam int POS_L3        = 2;
  localparam int POS_L2        = 1;
  localparam int POS_RSV_RW0   = 0;

  localparam logic [1:0] LPF_LOW      = 2'h0;
  localparam logic [1:0] LPF_MEDIUM   = 2'h1;
  localparam logic [1:0] LPF_HIGH     = 2'h2;
  localparam logic [1:0] LPF_RESERVED = 2'h3;

  typedef enum logic [1:0] {
    COMB_NONE,
    COMB_TWO_LINE,
    COMB_THREE_LINE
  } comb_choice_e;

  typedef struct packed {
    logic       luma_two_line_enable;
    logic       luma_three_line_enable;
    logic       chroma_two_line_enable;
    logic       chroma_three_line_enable;
    logic       adjacent_line_luma_check;
    logic       chroma_reduce_enable;
    logic [3:0] blend_slope;
    logic [1:0] luma_lowpass_bandwidth;
    logic [1:0] chroma_lowpass_bandwidth;
  } comb_ctrl_s;

endpackage

// >>> logic/cfg_byte_reg.sv
`timescale 1ns/1ps
// One byte of configuration storage with a writable-bit mask
module cfg_byte_reg
  import comb_cfg_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK  = 8'hff
) (
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       write_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] value_out
);

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      value_out <= RESET_VALUE;
    end else if (write_in) begin
      value_out <= (wdata_in & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
    end
  end

endmodule

// >>> logic/comb_adapt_select.sv
`timescale 1ns/1ps
// Picks the comb depth among those software still allows
module comb_adapt_select
  import comb_cfg_pkg::*;
(
  input  wire logic         three_line_enable_in,
  input  wire logic         two_line_enable_in,
  input  wire logic         prefer_three_in,
  input  wire logic         prefer_two_in,
  output comb_choice_e      choice_out
);

  wire want_three = prefer_three_in && three_line_enable_in;
  wire want_two   = prefer_two_in && two_line_enable_in;

  // Three-line wins when both are allowed and wanted
  assign choice_out = want_three ? COMB_THREE_LINE : (want_two ? COMB_TWO_LINE : COMB_NONE);

endmodule

// >>> logic/comb_filter_dto_config.sv
`timescale 1ns/1ps
module comb_filter_dto_config
  import comb_cfg_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              resetn_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  input  wire logic              ntsc_mode_in,
  input  wire logic              adjacent_luma_only_in,
  input  wire logic              prefer_three_in,
  input  wire logic              prefer_two_in,
  input  wire logic [7:0]        comb_error_in,
  input  wire logic [7:0]        chroma_in,
  input  wire logic              chroma_combed_in,
  input  wire logic [7:0]        ratio_trim_in,
  output logic                   pready_out,
  output logic [31:0]            prdata_out,
  output logic                   pslverr_out,
  output logic [9:0]             src_ratio_out,
  output logic [19:0]            subcarrier_step_out,
  output logic [19:0]            phase_out,
  output comb_ctrl_s             ctrl_out,
  output comb_choice_e           chroma_comb_out,
  output comb_choice_e           luma_comb_out,
  output logic                   luma_check_active_out,
  output logic [7:0]             chroma_out
);

  // Bus decode
  wire [11:0] reg_index  = paddr_in[ADDR_W-1:ADDR_SHIFT];
  wire        access     = psel_in && penable_in;
  wire        write_lane = pwrite_in && pstrb_in[0];
  wire        word_ok    = paddr_in[1:0] == 2'h0;
  wire        hit_rlow   = reg_index == IDX_SRC_RATIO_LOW;
  wire        hit_rhigh  = reg_index == IDX_SRC_RATIO_HIGH;
  wire        hit_bw     = reg_index == IDX_COMB_BW;
  wire        hit_en     = reg_index == IDX_COMB_EN;
  wire        hit_slow   = reg_index == IDX_STEP_LOW;
  wire        hit_smid   = reg_index == IDX_STEP_MID;
  wire        hit_shigh  = reg_index == IDX_STEP_HIGH;
  wire        mapped     = word_ok && (hit_rlow || hit_rhigh || hit_bw || hit_en
                                       || hit_slow || hit_smid || hit_shigh);
  // One wait state: pready answers the edge after the first access edge
  wire        do_access  = access && !pready_out;
  wire        do_write   = do_access && mapped && write_lane;

  wire [7:0] ratio_low_q;
  wire [7:0] ratio_high_q;
  wire [7:0] bw_q;
  wire [7:0] en_q;
  wire [7:0] step_low_q;
  wire [7:0] step_mid_q;
  wire [7:0] step_high_q;

  localparam logic [7:0] RST_RHIGH = {RST_REDUCE_EN, 5'h00, RST_SRC_RATIO_HIGH};
  localparam logic [7:0] RST_BW    = {RST_LPF_SEL, RST_LPF_SEL, RST_BLEND_SLOPE};
  localparam logic [7:0] RST_EN    = {RST_COMB_EN_BIT, RST_COMB_EN_BIT, RST_COMB_EN_BIT, 1'h0,
                                      1'h0, RST_COMB_EN_BIT, RST_COMB_EN_BIT, 1'h0};

  cfg_byte_reg #(.RESET_VALUE(RST_SRC_RATIO_LOW), .WRITE_MASK(8'hff)) u_ratio_low (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .write_in  (do_write && hit_rlow),
    .wdata_in  (pwdata_in[7:0]),
    .value_out (ratio_low_q)
  );

  cfg_byte_reg #(.RESET_VALUE(RST_RHIGH), .WRITE_MASK(8'h83)) u_ratio_high (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .write_in  (do_write && hit_rhigh),
    .wdata_in  (pwdata_in[7:0]),
    .value_out (ratio_high_q)
  );

  cfg_byte_reg #(.RESET_VALUE(RST_BW), .WRITE_MASK(8'hff)) u_bw (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .write_in  (do_write && hit_bw),
    .wdata_in  (pwdata_in[7:0]),
    .value_out (bw_q)
  );

  cfg_byte_reg #(.RESET_VALUE(RST_EN), .WRITE_MASK(8'hf7)) u_en (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .write_in  (do_write && hit_en),
    .wdata_in  (pwdata_in[7:0]),
    .value_out (en_q)
  );

  cfg_byte_reg #(.RESET_VALUE(RST_STEP_LOW), .WRITE_MASK(8'hff)) u_step_low (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .write_in  (do_write && hit_slow),
    .wdata_in  (pwdata_in[7:0]),
    .value_out (step_low_q)
  );

  cfg_byte_reg #(.RESET_VALUE(RST_STEP_MID), .WRITE_MASK(8'hff)) u_step_mid (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .write_in  (do_write && hit_smid),
    .wdata_in  (pwdata_in[7:0]),
    .value_out (step_mid_q)
  );

  cfg_byte_reg #(.RESET_VALUE({4'h0, RST_STEP_HIGH}), .WRITE_MASK(8'h0f)) u_step_high (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .write_in  (do_write && hit_shigh),
    .wdata_in  (pwdata_in[7:0]),
    .value_out (step_high_q)
  );

  wire [7:0] read_byte = hit_rlow  ? ratio_low_q  :
                         hit_rhigh ? ratio_high_q :
                         hit_bw    ? bw_q         :
                         hit_en    ? en_q         :
                         hit_slow  ? step_low_q   :
                         hit_smid  ? step_mid_q   :
                         hit_shigh ? step_high_q  : 8'h00;

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= do_access;
      pslverr_out <= do_access && !mapped;
      prdata_out  <= (do_access && mapped && !pwrite_in) ? {24'h00_0000, read_byte} : 32'h0000_0000;
    end
  end

  // Control fields decoded from storage
  comb_ctrl_s next_ctrl;
  assign next_ctrl.chroma_reduce_enable     = ratio_high_q[POS_REDUCE_EN];
  assign next_ctrl.luma_lowpass_bandwidth   = bw_q[POS_LUMA_LPF +: 2];
  assign next_ctrl.chroma_lowpass_bandwidth = bw_q[POS_CHROMA_LPF +: 2];
  assign next_ctrl.blend_slope              = (bw_q[3:0] > MAX_BLEND_SLOPE) ? MAX_BLEND_SLOPE : bw_q[3:0];
  assign next_ctrl.adjacent_line_luma_check = en_q[POS_CHECK];
  assign next_ctrl.chroma_three_line_enable = en_q[POS_C3];
  assign next_ctrl.chroma_two_line_enable   = en_q[POS_C2];
  assign next_ctrl.luma_three_line_enable   = en_q[POS_L3];
  assign next_ctrl.luma_two_line_enable     = en_q[POS_L2];

  comb_choice_e next_chroma_comb;
  comb_choice_e next_luma_comb;

  comb_adapt_select u_chroma_sel (
    .three_line_enable_in (next_ctrl.chroma_three_line_enable),
    .two_line_enable_in   (next_ctrl.chroma_two_line_enable),
    .prefer_three_in      (prefer_three_in),
    .prefer_two_in        (prefer_two_in),
    .choice_out           (next_chroma_comb)
  );

  comb_adapt_select u_luma_sel (
    .three_line_enable_in (next_ctrl.luma_three_line_enable),
    .two_line_enable_in   (next_ctrl.luma_two_line_enable),
    .prefer_three_in      (prefer_three_in),
    .prefer_two_in        (prefer_two_in),
    .choice_out           (next_luma_comb)
  );

  wire next_check = next_ctrl.adjacent_line_luma_check && ntsc_mode_in && adjacent_luma_only_in;

  wire [15:0] atten_prod   = 16'(chroma_in) * 16'(comb_error_in);
  wire [7:0]  atten_amount = atten_prod[15:8];
  wire        reduce_now   = next_ctrl.chroma_reduce_enable && !chroma_combed_in;
  wire [7:0]  next_chroma  = reduce_now ? chroma_in - atten_amount : chroma_in;

  wire [9:0]  next_ratio = {ratio_high_q[1:0], ratio_low_q};
  wire [19:0] next_step  = {step_high_q[3:0], step_mid_q, step_low_q};
  // device trims rate; oscillator runs on programmed step
  wire [19:0] next_phase = phase_out + next_step;

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      src_ratio_out         <= {RST_SRC_RATIO_HIGH, RST_SRC_RATIO_LOW};
      subcarrier_step_out   <= {RST_STEP_HIGH, RST_STEP_MID, RST_STEP_LOW};
      phase_out             <= 20'h0_0000;
      ctrl_out              <= '0;
      chroma_comb_out       <= COMB_NONE;
      luma_comb_out         <= COMB_NONE;
      luma_check_active_out <= 1'b0;
      chroma_out            <= 8'h00;
    end else begin
      src_ratio_out         <= next_ratio + {2'h0, ratio_trim_in};
      subcarrier_step_out   <= next_step;
      phase_out             <= next_phase;
      ctrl_out              <= next_ctrl;
      chroma_comb_out       <= next_chroma_comb;
      luma_comb_out         <= next_luma_comb;
      luma_check_active_out <= next_check;
      chroma_out            <= next_chroma;
    end
  end

  // Assertions
  reset_values_a: assert property (@(posedge mclk_in)
    $rose(resetn_in) |-> subcarrier_step_out == 20'h87c1f)
    else $error("step reset value wrong");

  three_chroma_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !en_q[POS_C3] |=> chroma_comb_out != COMB_THREE_LINE)
    else $error("disabled chroma three-line chosen");

  two_chroma_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (!en_q[POS_C2] && !prefer_three_in) |=> chroma_comb_out == COMB_NONE)
    else $error("disabled chroma two-line chosen");

  three_luma_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !en_q[POS_L3] |=> luma_comb_out != COMB_THREE_LINE)
    else $error("disabled luma three-line chosen");

  two_luma_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (!en_q[POS_L2] && !prefer_three_in) |=> luma_comb_out == COMB_NONE)
    else $error("disabled luma two-line chosen");

  ntsc_check_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !ntsc_mode_in |=> !luma_check_active_out)
    else $error("luma check outside NTSC");

  slope_range_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (bw_q[3:0] <= MAX_BLEND_SLOPE) |=> ctrl_out.blend_slope == $past(bw_q[3:0]))
    else $error("blend slope not passed through");

  slope_clamp_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (bw_q[3:0] > MAX_BLEND_SLOPE) |=> ctrl_out.blend_slope == MAX_BLEND_SLOPE)
    else $error("blend slope not clamped");

  reserved_zero_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ratio_high_q[6:2] == 5'h00 && en_q[3] == 1'b0 && step_high_q[7:4] == 4'h0)
    else $error("read-zero bit set");

  step_write_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (do_write && hit_smid) |=> ##1 subcarrier_step_out[15:8] == $past(pwdata_in[7:0], 2))
    else $error("middle step byte not applied");

  unreduced_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (chroma_combed_in || !ratio_high_q[POS_REDUCE_EN]) |=> chroma_out == $past(chroma_in))
    else $error("combed chroma altered");

  reduce_scale_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (reduce_now && comb_error_in[7] && chroma_in[7]) |=> chroma_out < $past(chroma_in))
    else $error("uncombed chroma not reduced");

  lpf_select_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    1'b1 |=> ctrl_out.luma_lowpass_bandwidth == $past(bw_q[7:6])
             && ctrl_out.chroma_lowpass_bandwidth == $past(bw_q[5:4]))
    else $error("bandwidth select not applied");

  ratio_bits_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (ratio_trim_in == 8'h00) |=> src_ratio_out == $past({ratio_high_q[1:0], ratio_low_q}))
    else $error("ratio bytes not assembled");

  luma_check_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (en_q[POS_CHECK] && ntsc_mode_in && adjacent_luma_only_in) |=> luma_check_active_out)
    else $error("luma check not raised");

  apb_ready_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (psel_in && penable_in && !pready_out) |=> pready_out)
    else $error("access not answered");

  write_cov: cover property (@(posedge mclk_in) do_write);
  unmapped_cov: cover property (@(posedge mclk_in) pslverr_out);
  reduce_cov: cover property (@(posedge mclk_in) resetn_in && reduce_now && comb_error_in != 8'h00);
  clamp_cov: cover property (@(posedge mclk_in) resetn_in && bw_q[3:0] > MAX_BLEND_SLOPE);

endmodule

// >>> verif/comb_filter_dto_config_bench.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin fails++; $display("unexpected at %0t: %s", $time, m); end end
module comb_filter_dto_config_bench;
  import comb_cfg_pkg::*;
  logic              mclk_in, resetn_in, psel, penable, pwrite, ntsc, adj, p3, p2, combed, pready, pslverr, lchk;
  logic [ADDR_W-1:0] paddr, ra;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        pstrb;
  logic [7:0]        cerr, chroma, trim, cout, d;
  logic [9:0]        ratio;
  logic [19:0]       step, phase, p0;
  logic              e;
  comb_ctrl_s        ctrl;
  comb_choice_e      ccomb, lcomb;
  int                fails, n_compared, i;
  // Readable bits and reset values, one entry per index from 0x478
  logic [7:0] rmask [7] = '{8'hff, 8'h83, 8'hff, 8'hf7, 8'hff, 8'hff, 8'h0f};
  logic [7:0] rdef  [7] = '{8'h1f, 8'h82, 8'h58, 8'he6, 8'h1f, 8'h7c, 8'h08};
  logic [7:0] sh    [7];

  comb_filter_dto_config u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .ntsc_mode_in(ntsc),
    .adjacent_luma_only_in(adj), .prefer_three_in(p3), .prefer_two_in(p2), .comb_error_in(cerr),
    .chroma_in(chroma), .chroma_combed_in(combed), .ratio_trim_in(trim), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .src_ratio_out(ratio), .subcarrier_step_out(step),
    .phase_out(phase), .ctrl_out(ctrl), .chroma_comb_out(ccomb), .luma_comb_out(lcomb),
    .luma_check_active_out(lchk), .chroma_out(cout));

  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  function automatic logic [ADDR_W-1:0] ba(input int k);
    return ADDR_W'({2'h0, IDX_SRC_RATIO_LOW + 12'(k)} << ADDR_SHIFT);
  endfunction

  function automatic comb_choice_e pick(input logic en3, input logic en2, input logic w3, input logic w2);
    if (en3 && w3) return COMB_THREE_LINE;
    if (en2 && w2) return COMB_TWO_LINE;
    return COMB_NONE;
  endfunction

  function automatic comb_ctrl_s exp_ctrl();
    comb_ctrl_s c;
    c.luma_two_line_enable     = sh[3][1];
    c.luma_three_line_enable   = sh[3][2];
    c.chroma_two_line_enable   = sh[3][5];
    c.chroma_three_line_enable = sh[3][6];
    c.adjacent_line_luma_check = sh[3][7];
    c.chroma_reduce_enable     = sh[1][7];
    // Slope codes above 8 act as 8
    c.blend_slope              = (sh[2][3:0] > 4'h8) ? 4'h8 : sh[2][3:0];
    c.luma_lowpass_bandwidth   = sh[2][7:6];
    c.chroma_lowpass_bandwidth = sh[2][5:4];
    return c;
  endfunction

  function automatic logic [7:0] exp_chroma();
    logic [15:0] pr;
    pr = 16'(chroma) * 16'(cerr);
    if (sh[1][7] && !combed) return chroma - pr[15:8];
    return chroma;
  endfunction

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] wd, input logic [3:0] st);
    int n;
    @(posedge mclk_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, wd}; pstrb <= st;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    // Answer is taken at the rising edge that shows pready high
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK(n < 20, 1'b1, "no pready")
    rd = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input int k, input logic [7:0] v, input logic [3:0] st);
    apb(1'b1, ba(k), v, st);
    `CHK(e, 1'b0, "write error")
    if (st[0]) sh[k] = v;
  endtask

  task automatic rdchk(input int k);
    apb(1'b0, ba(k), 8'h00, 4'hf);
    `CHK(rd, {24'h0, sh[k] & rmask[k]}, "read back")
  endtask

  task automatic check_outs();
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    `CHK(ratio, 10'({sh[1][1:0], sh[0]}) + 10'(trim), "ratio")
    `CHK(step, {sh[6][3:0], sh[5], sh[4]}, "step")
    `CHK(ctrl, exp_ctrl(), "controls")
    `CHK(lchk, sh[3][7] & ntsc & adj, "luma check")
    `CHK(ccomb, pick(sh[3][6], sh[3][5], p3, p2), "chroma comb")
    `CHK(lcomb, pick(sh[3][2], sh[3][1], p3, p2), "luma comb")
    `CHK(cout, exp_chroma(), "chroma")
    p0 = phase;
    @(negedge mclk_in);
    `CHK(phase, p0 + {sh[6][3:0], sh[5], sh[4]}, "phase")
  endtask

  task automatic do_reset();
    resetn_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    for (int k = 0; k < 7; k++) sh[k] = rdef[k];
    check_outs();
    for (int k = 0; k < 7; k++) rdchk(k);
    $display("test defaults done");
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(25 * 40000);
    fails++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, ntsc, adj, p3, p2, combed} = '0;
    paddr = '0; pwdata = '0; pstrb = '0; cerr = '0; chroma = '0; trim = '0;
    fails = 0; n_compared = 0;
    void'($urandom(99823));
    do_reset();
    // Every code of both bandwidth selects, slope edges 0, 8 and beyond
    for (int k = 0; k < 4; k++) begin
      wr(2, {2'(k), 2'(3 - k), (k == 0) ? 4'h0 : (k == 1) ? 4'h8 : (k == 2) ? 4'h9 : 4'hf}, 4'hf);
      check_outs();
    end
    $display("test bandwidth done");
    for (int m = 0; m < 16; m++) begin
      wr(3, {m[0], m[3], m[2], 1'b1, 1'b0, m[2], m[3], 1'b1}, 4'hf);
      @(posedge mclk_in);
      {p3, p2, ntsc, adj} <= {m[1], m[0], m[1], m[2]};
      check_outs();
    end
    $display("test comb enables done");
    // Unmapped and misaligned places refuse and store nothing
    for (int k = 0; k < 4; k++) begin
      ra = (k == 0) ? ba(-1) : (k == 1) ? ba(7) : ba(k) | ADDR_W'(k - 1);
      apb(1'b1, ra, 8'hff, 4'hf);
      `CHK(e, 1'b1, "write refusal")
      apb(1'b0, ra, 8'h00, 4'hf);
      `CHK({e, rd}, {1'b1, 32'h0}, "read refusal")
    end
    wr(4, 8'h55, 4'h0);
    for (int k = 0; k < 7; k++) rdchk(k);
    $display("test refusals done");
    // ratio written before the step bytes
    wr(1, 8'h01, 4'hf);
    wr(0, 8'hc0, 4'hf);
    for (i = 0; i < 40; i++) begin
      d = 8'($urandom);
      wr(4 + (i % 3), d, 4'hf);
      wr($urandom_range(6), 8'($urandom), ($urandom_range(3) == 0) ? 4'h0 : 4'hf);
      @(posedge mclk_in);
      {p3, p2, ntsc, adj, combed} <= 5'($urandom);
      cerr <= 8'($urandom);
      chroma <= 8'($urandom);
      trim <= (i < 4) ? 8'hff : 8'($urandom);
      check_outs();
      rdchk($urandom_range(6));
    end
    $display("test random done");
    do_reset();
    tally_and_finish();
  end
endmodule
